// ### hdl/rcs_remote_port.sv
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - seven command inputs and four condition outputs, each configurable.
// - each input takes one command; default off means no action.
// - button-function input does that button's job; held button overrides.
// - fixed mode: rebuild lowers, ramp-zero raises, sneeze selects digit.
// - live cancels every command except dump into rebuild, whose rebuild still follows, and goes to zero delay.
// - static cancels current function, holds delay; ignored in fixed mode.
// - full delay enters static at full delay; ignored in fixed mode.
// - mute input mutes audio and reports mute mode while held.
// - station break mutes, buffers until 4 s, then starts ramp to zero.
// - ramp to bypass ramps to zero then goes straight to bypass.
// - dump into rebuild dumps then rebuilds, even at zero; not in fixed mode.
// - wait-exit/rebuild toggle: rebuild at zero delay, else wait and exit.
// - ramp-zero/rebuild toggle: rebuild at zero delay, else ramp to zero.
// - outputs open if inactive, grounded if active; off open, on grounded.
// - bypass output grounds when bypassed; live output in-line at zero delay.
// - wait-safe, wait-exit, ramp-zero outputs ground during that operation.
// - full output at full delay; safe output above safe time.
// - rebuild-mode output while rebuilding or at max, off in sneeze or mute.
// - rebuilding output only below max, off in sneeze or mute.
// - mute, dump, station break outputs ground while that operation runs.
// - unlock output when digital input selected without signal.
// - ready in run-time; error with non-empty log; all-ok needs both.
module rcs_remote_port #(
    parameter int unsigned TICK_CYC = rcs_pkg::TICK_CYCLES,
    parameter int unsigned DB_TICKS = rcs_pkg::DEBOUNCE_MS
) (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [31:0]                 s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [31:0]                 s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic [rcs_pkg::NUM_IN-1:0]  remote_in,
    output logic [rcs_pkg::NUM_OUT-1:0]      remote_out_o,
    output logic [rcs_pkg::NUM_OUT-1:0]      remote_out_oe,
    input  wire logic [rcs_pkg::NUM_BTN-1:0] panel_held,
    input  wire rcs_pkg::rcs_unit_t          unit,
    output rcs_pkg::rcs_cmd_t                cmd
);
    import rcs_pkg::*;

    localparam int unsigned TW = $clog2(TICK_CYC + 1);
    localparam int unsigned DW = $clog2(DB_TICKS + 1);

    // ---------------- configuration storage ----------------
    logic [CFG_W-1:0]   in_cfg_reg  [NUM_IN];
    logic [CFG_W-1:0]   out_cfg_reg [NUM_OUT];
    logic               enable_reg;

    // ---------------- bus slave ----------------
    logic [7:0]         aw_addr_reg;
    logic               aw_hold_reg;
    logic [31:0]        w_data_reg;
    logic [3:0]         w_strb_reg;
    logic               w_hold_reg;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take  = s_axi_wvalid && s_axi_wready;
    wire do_wr   = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    wire b_done  = s_axi_bvalid && s_axi_bready;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire r_done  = s_axi_rvalid && s_axi_rready;

    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] base,
                                      input int unsigned n);
        logic [7:0] top;
        top = 8'(base + 8'(n * 4));
        return (a[1:0] == 2'h0) && (a >= base) && (a < top);
    endfunction

    function automatic int unsigned word_idx(input logic [7:0] a,
                                             input logic [7:0] base);
        return int'(8'(a - base) >> 2);
    endfunction

    wire wr_in   = addr_hit(aw_addr_reg, IN_CFG_BASE, NUM_IN);
    wire wr_out  = addr_hit(aw_addr_reg, OUT_CFG_BASE, NUM_OUT);
    wire wr_ctrl = (aw_addr_reg == CTRL_OFS);
    wire wr_ok   = wr_in || wr_out || wr_ctrl;

    // a byte lane 0 strobe is enough: every field lives in the low byte
    wire wr_lane0 = w_strb_reg[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_hold_reg   <= 1'b0;
            w_hold_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_addr_reg   <= s_axi_awaddr[7:0];
                aw_hold_reg   <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
                w_hold_reg   <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (b_done) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_IN; i++) in_cfg_reg[i] <= CFG_RESET;
            for (int i = 0; i < NUM_OUT; i++) out_cfg_reg[i] <= CFG_RESET;
            enable_reg <= CTRL_RESET[0];
        end else if (do_wr && wr_lane0) begin
            if (wr_in)
                in_cfg_reg[word_idx(aw_addr_reg, IN_CFG_BASE)] <=
                    w_data_reg[CFG_W-1:0];
            if (wr_out)
                out_cfg_reg[word_idx(aw_addr_reg, OUT_CFG_BASE)] <=
                    w_data_reg[CFG_W-1:0];
            if (wr_ctrl)
                enable_reg <= w_data_reg[0];
        end
    end

    // ---------------- input synchroniser and debounce ----------------
    logic [NUM_IN-1:0]  sync1_reg;
    logic [NUM_IN-1:0]  sync2_reg;
    logic [NUM_IN-1:0]  stable_reg;
    logic [NUM_IN-1:0]  rise_reg;
    logic [DW-1:0]      db_cnt_reg [NUM_IN];
    logic [TW-1:0]      tick_cnt_reg;
    logic               tick_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg    <= '0;
            sync2_reg    <= '0;
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b0;
        end else begin
            sync1_reg <= remote_in;
            sync2_reg <= sync1_reg;
            tick_reg  <= (tick_cnt_reg == TW'(TICK_CYC - 1));
            tick_cnt_reg <= (tick_cnt_reg == TW'(TICK_CYC - 1)) ? '0
                          : TW'(tick_cnt_reg + 1'b1);
        end
    end

    // a level must differ from the stable one on DB_TICKS successive tick pulses;
    // contact bounce shorter than that never reaches the command logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stable_reg <= '0;
            rise_reg   <= '0;
            for (int i = 0; i < NUM_IN; i++) db_cnt_reg[i] <= '0;
        end else begin
            rise_reg <= '0;
            for (int i = 0; i < NUM_IN; i++) begin
                if (sync2_reg[i] == stable_reg[i]) begin
                    db_cnt_reg[i] <= '0;
                end else if (tick_reg) begin
                    if (db_cnt_reg[i] == DW'(DB_TICKS - 1)) begin
                        stable_reg[i] <= sync2_reg[i];
                        rise_reg[i]   <= sync2_reg[i];
                        db_cnt_reg[i] <= '0;
                    end else begin
                        db_cnt_reg[i] <= DW'(db_cnt_reg[i] + 1'b1);
                    end
                end
            end
        end
    end

    // ---------------- command decode ----------------
    function automatic logic fires(input logic [NUM_IN-1:0] ev,
                                   input logic [4:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NUM_IN; i++)
            hit = hit | (ev[i] && in_cfg_reg[i] == code);
        return hit;
    endfunction

    // a held panel button wins over the same remote function
    function automatic logic btn(input rcs_in_cmd_t code);
        return fires(rise_reg, code) && !panel_held[int'(code) - 1];
    endfunction

    wire fixed      = unit.fixed_mode;
    wire at_zero    = (unit.delay_cs == 16'h0000);
    wire go         = enable_reg;

    wire t_bypass   = go && btn(IC_BYPASS);
    wire t_config   = go && btn(IC_CONFIG);
    wire t_wsafe    = go && btn(IC_WAIT_SAFE);
    wire t_wexit    = go && btn(IC_WAIT_EXIT);
    wire t_rebuild  = go && btn(IC_REBUILD);
    wire t_rzero    = go && btn(IC_RAMP_ZERO);
    wire t_sneeze   = go && btn(IC_SNEEZE);
    wire t_dump     = go && btn(IC_DUMP);
    wire t_live     = go && fires(rise_reg, IC_LIVE);
    wire t_static   = go && fires(rise_reg, IC_STATIC) && !fixed;
    wire t_full     = go && fires(rise_reg, IC_FULL) && !fixed;
    wire t_sbi      = go && fires(rise_reg, IC_SBI);
    wire t_rbyp     = go && fires(rise_reg, IC_RAMP_BYP);
    wire t_dreb     = go && fires(rise_reg, IC_DUMP_REB) && !fixed;
    wire t_wereb    = go && fires(rise_reg, IC_WE_REB);
    wire t_rzreb    = go && fires(rise_reg, IC_RZ_REB);
    wire mute_lvl   = go && fires(stable_reg, IC_MUTE);

    // ---------------- sequenced commands ----------------
    logic sbi_reg;
    logic rbyp_reg;
    logic dreb_reg;

    wire sbi_end  = sbi_reg && (unit.delay_cs >= SBI_END_CS);
    wire rbyp_end = rbyp_reg && at_zero && !unit.bypassed;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sbi_reg  <= 1'b0;
            rbyp_reg <= 1'b0;
            dreb_reg <= 1'b0;
        end else begin
            // live cancels the station break and ramp-to-bypass sequences, not dump into rebuild
            if (t_live) begin
                sbi_reg  <= 1'b0;
                rbyp_reg <= 1'b0;
            end else begin
                if (t_sbi)
                    sbi_reg <= 1'b1;
                else if (sbi_end || t_static || t_full)
                    sbi_reg <= 1'b0;
                if (t_rbyp)
                    rbyp_reg <= 1'b1;
                else if (rbyp_end || t_static || t_full)
                    rbyp_reg <= 1'b0;
            end
            dreb_reg <= t_dreb;
        end
    end

    // ---------------- command outputs ----------------
    rcs_cmd_t cmd_next;

    always_comb begin
        cmd_next = '0;
        cmd_next.bypass_cmd     = t_bypass || rbyp_end;
        cmd_next.configure_cmd  = t_config;
        cmd_next.wait_safe_cmd  = t_wsafe;
        cmd_next.wait_exit_cmd  = t_wexit || (t_wereb && !at_zero);
        cmd_next.rebuild_cmd    = (t_rebuild && !fixed) || dreb_reg
                                || ((t_wereb || t_rzreb) && at_zero);
        cmd_next.ramp_zero_cmd  = (t_rzero && !fixed) || sbi_end
                                || (t_rbyp && !at_zero)
                                || (t_rzreb && !at_zero);
        cmd_next.sneeze_cmd     = t_sneeze && !fixed;
        cmd_next.dump_cmd       = t_dump || t_dreb;
        cmd_next.decrement_cmd  = t_rebuild && fixed;
        cmd_next.increment_cmd  = t_rzero && fixed;
        cmd_next.digit_sel_cmd  = t_sneeze && fixed;
        cmd_next.cancel_all_cmd = t_live;
        cmd_next.go_zero_cmd    = t_live;
        cmd_next.static_cmd     = t_static || t_full;
        cmd_next.full_delay_cmd = t_full;
        cmd_next.mute_level     = mute_lvl;
        cmd_next.audio_mute     = mute_lvl || sbi_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            cmd <= '0;
        else
            cmd <= cmd_next;
    end

    // ---------------- condition outputs ----------------
    // mute mode replaces the operation reports while the mute level is held; bypass, live, full and safe still report
    wire mm        = mute_lvl;
    wire inline_u  = !unit.bypassed;
    wire reb_quiet = mm || unit.sneeze_busy;
    wire rdy       = unit.run_time;

    function automatic logic cond(input logic [4:0] code);
        logic c;
        c = 1'b0;
        unique case (code)
            OC_ON:         c = 1'b1;
            OC_BYPASS:     c = unit.bypassed;
            OC_LIVE:       c = inline_u && at_zero;
            OC_WAIT_SAFE:  c = unit.wait_safe_busy && !mm;
            OC_WAIT_EXIT:  c = unit.wait_exit_busy && !mm;
            OC_RAMP_ZERO:  c = (unit.ramp_zero_busy || rbyp_reg) && !mm;
            OC_FULL:       c = unit.delay_cs >= unit.full_cs;
            OC_SAFE:       c = unit.delay_cs > unit.safe_cs;
            OC_REB_MODE:   c = unit.rebuild_mode && !reb_quiet;
            OC_REBUILDING: c = unit.rebuild_mode && !unit.at_max
                               && !reb_quiet;
            OC_MUTE:       c = mm;
            OC_DUMP:       c = unit.dump_busy && !mm;
            OC_SBI:        c = sbi_reg && !mm;
            OC_UNLOCK:     c = unit.digital_sel && !unit.audio_locked;
            OC_READY:      c = rdy && go;
            OC_ERROR:      c = !unit.log_empty;
            OC_ALL_OK:     c = rdy && go && unit.log_empty;
            default:       c = 1'b0;
        endcase
        return c;
    endfunction

    logic [NUM_OUT-1:0] oe_next;

    always_comb begin
        for (int i = 0; i < NUM_OUT; i++) oe_next[i] = cond(out_cfg_reg[i]);
    end

    // open collector: the pin is only ever pulled low, never driven high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            remote_out_oe <= '0;
            remote_out_o  <= '0;
        end else begin
            remote_out_oe <= oe_next;
            remote_out_o  <= '0;
        end
    end

    // ---------------- read path ----------------
    wire [7:0] ra     = s_axi_araddr[7:0];
    wire       rd_in  = addr_hit(ra, IN_CFG_BASE, NUM_IN);
    wire       rd_out = addr_hit(ra, OUT_CFG_BASE, NUM_OUT);
    wire       rd_st  = (ra == STATUS_OFS);
    wire       rd_ctl = (ra == CTRL_OFS);
    wire       rd_ok  = rd_in || rd_out || rd_st || rd_ctl;

    logic [31:0] rd_word;

    always_comb begin
        rd_word = 32'h0000_0000;
        if (rd_in)
            rd_word[CFG_W-1:0] = in_cfg_reg[word_idx(ra, IN_CFG_BASE)];
        else if (rd_out)
            rd_word[CFG_W-1:0] = out_cfg_reg[word_idx(ra, OUT_CFG_BASE)];
        else if (rd_st)
            rd_word[18:0] = {dreb_reg, rbyp_reg, sbi_reg, mute_lvl,
                             remote_out_oe, 1'b0, stable_reg, 1'b0,
                             sync2_reg[NUM_IN-1:NUM_IN-1], 1'b0};
        else if (rd_ctl)
            rd_word[0] = enable_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            if (ar_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (r_done) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

// ### inc/rcs_pkg.sv
package rcs_pkg;

    // clock and timing
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned TICK_US       = 1000;
    localparam int unsigned TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned DEBOUNCE_MS   = 10;
    localparam int unsigned SBI_END_S     = 4;
    localparam logic [15:0] SBI_END_CS    = 16'(SBI_END_S * 100);

    // port sizes
    localparam int unsigned NUM_IN        = 7;
    localparam int unsigned NUM_OUT       = 4;
    localparam int unsigned NUM_BTN       = 8;

    // register byte offsets
    localparam logic [7:0] IN_CFG_BASE    = 8'h00;
    localparam logic [7:0] OUT_CFG_BASE   = 8'h20;
    localparam logic [7:0] STATUS_OFS     = 8'h30;
    localparam logic [7:0] CTRL_OFS       = 8'h34;

    // field layout and reset values
    localparam int unsigned CFG_W         = 5;
    localparam logic [4:0]  CFG_RESET     = 5'h00;
    localparam logic [0:0]  CTRL_RESET    = 1'h1;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // input command codes; the eight after IC_OFF are front panel buttons
    typedef enum logic [4:0] {
        IC_OFF = 5'h00, IC_BYPASS = 5'h01, IC_CONFIG = 5'h02,
        IC_WAIT_SAFE = 5'h03, IC_WAIT_EXIT = 5'h04, IC_REBUILD = 5'h05,
        IC_RAMP_ZERO = 5'h06, IC_SNEEZE = 5'h07, IC_DUMP = 5'h08,
        IC_LIVE = 5'h09, IC_STATIC = 5'h0A, IC_FULL = 5'h0B,
        IC_MUTE = 5'h0C, IC_SBI = 5'h0D, IC_RAMP_BYP = 5'h0E,
        IC_DUMP_REB = 5'h0F, IC_WE_REB = 5'h10, IC_RZ_REB = 5'h11
    } rcs_in_cmd_t;

    // output condition codes
    typedef enum logic [4:0] {
        OC_OFF = 5'h00, OC_ON = 5'h01, OC_BYPASS = 5'h02, OC_LIVE = 5'h03,
        OC_WAIT_SAFE = 5'h04, OC_FULL = 5'h05, OC_SAFE = 5'h06,
        OC_WAIT_EXIT = 5'h07, OC_RAMP_ZERO = 5'h08, OC_REB_MODE = 5'h09,
        OC_REBUILDING = 5'h0A, OC_MUTE = 5'h0B, OC_DUMP = 5'h0C,
        OC_UNLOCK = 5'h0D, OC_SBI = 5'h0E, OC_READY = 5'h0F,
        OC_ERROR = 5'h10, OC_ALL_OK = 5'h11
    } rcs_out_cond_t;

    // unit state reported by the main controller (same clock)
    typedef struct packed {
        logic        bypassed;
        logic        fixed_mode;
        logic        wait_safe_busy;
        logic        wait_exit_busy;
        logic        ramp_zero_busy;
        logic        rebuild_mode;
        logic        at_max;
        logic        sneeze_busy;
        logic        dump_busy;
        logic        digital_sel;
        logic        audio_locked;
        logic        run_time;
        logic        log_empty;
        logic [15:0] delay_cs;
        logic [15:0] full_cs;
        logic [15:0] safe_cs;
    } rcs_unit_t;

    // command pulses (mute is a level) towards the controller
    typedef struct packed {
        logic bypass_cmd;
        logic configure_cmd;
        logic wait_safe_cmd;
        logic wait_exit_cmd;
        logic rebuild_cmd;
        logic ramp_zero_cmd;
        logic sneeze_cmd;
        logic dump_cmd;
        logic decrement_cmd;
        logic increment_cmd;
        logic digit_sel_cmd;
        logic cancel_all_cmd;
        logic go_zero_cmd;
        logic static_cmd;
        logic full_delay_cmd;
        logic mute_level;
        logic audio_mute;
    } rcs_cmd_t;

endpackage

// ### tb/rcs_remote_port_properties.sv
`timescale 1ns/1ps
module rcs_remote_port_checker (
    input wire logic                        aclk,
    input wire logic                        aresetn,
    input wire logic [rcs_pkg::NUM_OUT-1:0] remote_out_o,
    input wire logic [rcs_pkg::NUM_OUT-1:0] remote_out_oe,
    input wire logic [rcs_pkg::NUM_BTN-1:0] panel_held,
    input wire rcs_pkg::rcs_unit_t          unit,
    input wire rcs_pkg::rcs_cmd_t           cmd
);
    import rcs_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_oc_low; remote_out_o == '0; endproperty
    property p_pulse; cmd.dump_cmd |=> !cmd.dump_cmd; endproperty
    property p_live; cmd.cancel_all_cmd == cmd.go_zero_cmd; endproperty
    property p_full; cmd.full_delay_cmd |-> cmd.static_cmd; endproperty
    property p_fixed;
        $past(unit.fixed_mode) |-> !(cmd.static_cmd || cmd.full_delay_cmd);
    endproperty
    property p_mute; cmd.mute_level |-> cmd.audio_mute; endproperty
    property p_panel; $past(panel_held[6]) |-> !cmd.sneeze_cmd; endproperty
    // reset must hold the pins open even though it disables the rest
    property p_oe_rst;
        disable iff (1'b0) !aresetn |=> remote_out_oe == '0;
    endproperty
    a_oc_low: assert property (p_oc_low) else $error("pin driven");
    a_pulse: assert property (p_pulse) else $error("dump not a pulse");
    a_live: assert property (p_live) else $error("live pair split");
    a_full: assert property (p_full) else $error("full without static");
    a_fixed: assert property (p_fixed) else $error("static in fixed");
    a_mute: assert property (p_mute) else $error("mute not muting");
    a_panel: assert property (p_panel) else $error("panel not winning");
    a_oe_rst: assert property (p_oe_rst) else $error("pin not open");
    c_dump: cover property (cmd.dump_cmd);
    c_mute: cover property (cmd.mute_level);
    c_all_on: cover property (remote_out_oe == 4'hF);
endmodule
bind rcs_remote_port rcs_remote_port_checker chk_i (.aclk, .aresetn,
    .remote_out_o, .remote_out_oe, .panel_held, .unit, .cmd);

// ### tb/rcs_field_model.sv
`timescale 1ns/1ps
module rcs_field_model (
    input  wire logic [rcs_pkg::NUM_IN-1:0]  sw_closed,
    input  wire logic [rcs_pkg::NUM_OUT-1:0] remote_out_oe,
    output logic [rcs_pkg::NUM_IN-1:0]       remote_in,
    output logic [rcs_pkg::NUM_OUT-1:0]      pin_level
);
    // dry contacts: closed drives the input high, open floats to low
    assign remote_in = sw_closed;
    // released pins sit at the pull-up, grounded ones read low
    assign pin_level = ~remote_out_oe;
endmodule

// ### tb/remote_control_signalling_tb_top.sv
`timescale 1ns/1ps
module remote_control_signalling_tb_top;
    import rcs_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, clr = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_rvalid, s_axi_bvalid;
    logic        s_axi_awready, s_axi_wready, s_axi_arready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [6:0]  remote_in, sw_closed = '0;
    logic [3:0]  remote_out_o, remote_out_oe, pin_level;
    logic [7:0]  panel_held = '0;
    rcs_unit_t   unit;
    rcs_cmd_t    cmd, acc = '0;
    int          fails = 0, n_tests = 0;
    rcs_out_cond_t oc [4] = '{OC_ON, OC_BYPASS, OC_FULL, OC_SAFE};
    logic [16:0] exp_tab [18] = '{17'h00000, 17'h10000, 17'h08000,
        17'h04000, 17'h02000, 17'h01000, 17'h00800, 17'h00400, 17'h00200,
        17'h00030, 17'h00008, 17'h0000C, 17'h00003, 17'h00000, 17'h00000,
        17'h01200, 17'h02000, 17'h00800};
    rcs_remote_port #(.TICK_CYC(4), .DB_TICKS(2)) rcs_remote_port_i (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .remote_in, .remote_out_o,
        .remote_out_oe, .panel_held, .unit, .cmd);
    rcs_field_model rcs_field_model_i (.sw_closed, .remote_out_oe,
        .remote_in, .pin_level);
    initial forever #5 aclk = ~aclk;
    // pulses last one cycle, so they are gathered rather than polled
    always @(posedge aclk) acc <= clr ? '0 : (acc | cmd);
    task automatic chk(input string what, input logic [31:0] e, s);
        n_tests++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= {24'h000000, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        while (!s_axi_bvalid) @(posedge aclk);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdt(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= {24'h000000, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge aclk);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic step(input logic b, input logic [15:0] d);
        @(posedge aclk);
        unit.bypassed <= b;
        unit.delay_cs <= d;
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        repeat (10) @(posedge aclk);
    endtask
    task automatic press(input int i, input logic [4:0] c, logic [16:0] e);
        wr(IN_CFG_BASE + 8'(4 * i), {27'h0, c});
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        sw_closed[i] <= 1'b1;
        repeat (30) @(posedge aclk);
        sw_closed[i] <= 1'b0;
        repeat (30) @(posedge aclk);
        chk("cmd", {15'h0, e}, {15'h0, acc});
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        end_of_test;
    end
    initial begin
        unit = '0;
        {unit.delay_cs, unit.full_cs} = {16'h0064, 16'h03E8};
        {unit.safe_cs, unit.run_time, unit.log_empty} = {16'h0190, 2'h3};
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("oe", 32'h0, {28'h0, remote_out_oe});
        rdt(CTRL_OFS);
        chk("ctrl", 32'h1, rd);
        rdt(IN_CFG_BASE);
        chk("in_cfg", 32'h0, rd);
        rdt(8'h40);
        chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        wr(8'h40, 32'h1F);
        chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        $display("test registers done");
        press(0, IC_OFF, 17'h00000);
        for (int c = 1; c < 18; c++) begin
            if (c != 13 && c != 14) press(c % 7, 5'(c), exp_tab[c]);
        end
        step(1'b0, 16'h0000);
        press(1, IC_WE_REB, 17'h01000);
        press(2, IC_RZ_REB, 17'h01000);
        press(3, IC_DUMP_REB, 17'h01200);
        step(1'b0, 16'h0064);
        unit.fixed_mode <= 1'b1;
        press(4, IC_REBUILD, 17'h00100);
        press(5, IC_RAMP_ZERO, 17'h00080);
        press(6, IC_SNEEZE, 17'h00040);
        press(0, IC_STATIC, 17'h00000);
        press(1, IC_FULL, 17'h00000);
        press(2, IC_DUMP_REB, 17'h00000);
        unit.fixed_mode <= 1'b0;
        panel_held[6] <= 1'b1;
        press(3, IC_SNEEZE, 17'h00000);
        panel_held <= '0;
        $display("test modes done");
        press(4, IC_SBI, 17'h00001);
        step(1'b0, SBI_END_CS);
        chk("sbi", 32'h2, {30'h0, acc.ramp_zero_cmd, cmd.audio_mute});
        press(5, IC_RAMP_BYP, 17'h00800);
        step(1'b0, 16'h0000);
        chk("rbyp", 32'h10000, {15'h0, acc});
        $display("test sequences done");
        for (int j = 0; j < 4; j++) wr(OUT_CFG_BASE + 8'(4 * j), 32'(oc[j]));
        step(1'b0, 16'h0000);
        chk("pin", 32'hE, {28'h0, pin_level});
        step(1'b1, 16'h03E8);
        chk("pin", 32'h0, {28'h0, pin_level});
        // delay equal to the safe time is not above it
        step(1'b0, 16'h0190);
        chk("pin", 32'hE, {28'h0, pin_level});
        wr(OUT_CFG_BASE + 8'h04, 32'(OC_LIVE));
        step(1'b0, 16'h0000);
        chk("pin", 32'hC, {28'h0, pin_level});
        $display("test outputs done");
        end_of_test;
    end
endmodule
